// >>> reset_seq_defs.svh
// Timing counts, vector addresses and register offsets of the reset sequencer.
`ifndef RESET_SEQ_DEFS_SVH
`define RESET_SEQ_DEFS_SVH
`define OSC_STARTUP_CYCLES   13'h1000
`define RECOVERY_LOW_CYCLES  5'h10
`define SAMPLE_DELAY_CYCLES  4'h9
`define VEC_NORMAL           16'hFFFE
`define VEC_CLOCK_FAIL       16'hFFFC
`define VEC_WATCHDOG         16'hFFFA
`define REG_STATUS           12'h000
`define REG_MASK             12'h004
`define REG_CONTROL          12'h008
`define REG_VECTOR           12'h00C
`define STATUS_WIDTH         4
`define CONTROL_RESET        2'h3
`define MODE_RESET           3'h0
`endif

// >>> reset_seq_pkg.sv
// Types shared by the reset sequencer.
package reset_seq_pkg;
  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_STARTUP = 5'h02,
    ST_DRIVE   = 5'h04,
    ST_SETTLE  = 5'h08,
    ST_HOLD    = 5'h10
  } seq_state_t;
  typedef struct packed {
    logic       nmi_mask;
    logic       irq_mask;
    logic       irq_enable;
    logic       irq_level;
    logic       pullup_on;
  } int_defaults_t;
endpackage

// >>> reset_sequencer.sv
// Reset sequencer: cause merge, stretch, pin sampling, vector select, AXI4-Lite regs.
// Operation
// - Power-on, enabled watchdog timeout, enabled clock failure or external low pin start reset.
// - Power-on entry is asynchronous; other causes and the release are synchronized to the clock.
// - Any reset cause drives the open-drain reset pin low while a clocked sequence runs.
// - Power-on and clock-failure resets first wait 4096 cycles with the pin held low.
// - The recovery step drives the pin low for 16 cycles and then releases it.
// - Nine cycles after release the pin level is sampled to judge the reset source.
// - A low sample means external reset, clears both latches and selects FFFE.
// - A high sample with clock failure latched selects FFFC.
// - A high sample with only the watchdog latched selects FFFA.
// - A high sample with nothing latched selects FFFE.
// - Mode pins are captured during reset and the two mode pins get pull-downs in reset.
// - The maskable request is enabled, level sensitive, masked and pulled up at reset.
// - The nonmaskable mask bit is set during reset until software clears it.
`timescale 1ns/100ps
`include "reset_seq_defs.svh"
module reset_sequencer
  import reset_seq_pkg::*;
#(
  parameter int STARTUP_CYCLES = `OSC_STARTUP_CYCLES
) (
  // Clock and power-on reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Reset causes from the watchdog and the clock monitor.
  input  wire logic        watchdog_timeout,
  input  wire logic        clock_fail,
  // Bidirectional open-drain reset pin; enable low means driving low.
  input  wire logic        reset_pin_i,
  output logic             reset_pin_o,
  output logic             reset_pin_oe_n,
  // Mode pins and their pull-downs.
  input  wire logic        mode_pin_a,
  input  wire logic        mode_pin_b,
  input  wire logic        special_mode_pin_n,
  output logic             mode_pulldown_en,
  output logic [2:0]       mode_latched,
  // Core side.
  output logic             core_reset_n,
  output logic [15:0]      reset_vector,
  output int_defaults_t    int_defaults,
  input  wire logic        nmi_mask_clear,
  // Interrupt output.
  output logic             irq,
  // AXI4-Lite slave.
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  seq_state_t  state_q;
  logic [12:0] cnt_q;
  logic [1:0]  pin_sync_q;
  logic [1:0]  wd_sync_q;
  logic [1:0]  cf_sync_q;
  logic [2:0]  mode_s1_q;
  logic [2:0]  mode_s2_q;
  logic        wd_latch_q;
  logic        cf_latch_q;
  logic        pin_prev_q;
  logic [1:0]  control_q;
  logic [3:0]  status_q;
  logic [3:0]  mask_q;
  logic [3:0]  events;
  logic        pin_low;
  logic        wd_req;
  logic        cf_req;
  logic        sample_now;
  logic        nmi_mask_q;
  logic        aw_q;
  logic        w_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic        do_write;

  // Pin and cause inputs come from outside this clock; two stages before use.
  always_ff @(posedge aclk) begin
    pin_sync_q <= {pin_sync_q[0], reset_pin_i};
    wd_sync_q  <= {wd_sync_q[0], watchdog_timeout};
    cf_sync_q  <= {cf_sync_q[0], clock_fail};
  end

  // Mode straps are board pins as well; two stages before capture.
  always_ff @(posedge aclk) begin
    mode_s1_q <= {special_mode_pin_n, mode_pin_b, mode_pin_a};
    mode_s2_q <= mode_s1_q;
  end

  // Causes are gated by their enables; the pin reaches the sample two cycles late.
  assign pin_low = ~pin_sync_q[1];
  assign wd_req  = wd_sync_q[1] & control_q[0];
  assign cf_req  = cf_sync_q[1] & control_q[1];
  assign sample_now = (state_q == ST_SETTLE) && (cnt_q == 13'(`SAMPLE_DELAY_CYCLES - 1));

  // Cause latches hold through the sequence and are judged at the sample point.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_latch_q <= 1'b0;
      cf_latch_q <= 1'b0;
    end else if (sample_now && pin_low) begin
      wd_latch_q <= 1'b0;
      cf_latch_q <= 1'b0;
    end else begin
      if (wd_req) wd_latch_q <= 1'b1;
      if (cf_req) cf_latch_q <= 1'b1;
    end
  end

  // Sequencer. The pin low level caused by our own drive is ignored while driving.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_STARTUP;
      cnt_q   <= 13'h0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          cnt_q <= 13'h0;
          if (cf_req) state_q <= ST_STARTUP;
          else if (wd_req || pin_low) state_q <= ST_DRIVE;
        end
        ST_STARTUP: begin
          if (cnt_q == 13'(STARTUP_CYCLES - 1)) begin
            state_q <= ST_DRIVE;
            cnt_q   <= 13'h0;
          end else begin
            cnt_q <= cnt_q + 13'h1;
          end
        end
        ST_DRIVE: begin
          if (cnt_q == 13'(`RECOVERY_LOW_CYCLES - 1)) begin
            state_q <= ST_SETTLE;
            cnt_q   <= 13'h0;
          end else begin
            cnt_q <= cnt_q + 13'h1;
          end
        end
        ST_SETTLE: begin
          if (sample_now) begin
            state_q <= pin_low ? ST_HOLD : ST_IDLE;
            cnt_q   <= 13'h0;
          end else begin
            cnt_q <= cnt_q + 13'h1;
          end
        end
        ST_HOLD: begin
          // External reset: stay in reset until the pin is released.
          cnt_q <= 13'h0;
          if (!pin_low) state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_STARTUP;
          cnt_q   <= 13'h0;
        end
      endcase
    end
  end

  // Open-drain drive: only a low level is ever driven.
  assign reset_pin_o    = 1'b0;
  assign reset_pin_oe_n = ~((state_q == ST_STARTUP) || (state_q == ST_DRIVE));
  // Core stays in reset from entry until the sequencer returns to idle.
  assign core_reset_n   = aresetn && (state_q == ST_IDLE);
  assign mode_pulldown_en = ~core_reset_n;

  // Vector choice at the sample point; external reset clears the latches at the same edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_vector <= `VEC_NORMAL;
    end else if (sample_now) begin
      if (pin_low) reset_vector <= `VEC_NORMAL;
      else if (cf_latch_q) reset_vector <= `VEC_CLOCK_FAIL;
      else if (wd_latch_q) reset_vector <= `VEC_WATCHDOG;
      else reset_vector <= `VEC_NORMAL;
    end
  end

  // Mode pins are captured continuously while in reset, frozen after.
  always_ff @(posedge aclk) begin
    if (!aresetn) mode_latched <= `MODE_RESET;
    else if (!core_reset_n) mode_latched <= mode_s2_q;
  end

  // Nonmaskable mask is set through reset and cleared only by software.
  always_ff @(posedge aclk) begin
    if (!aresetn) nmi_mask_q <= 1'b1;
    else if (!core_reset_n) nmi_mask_q <= 1'b1;
    else if (nmi_mask_clear) nmi_mask_q <= 1'b0;
  end

  assign int_defaults.nmi_mask   = nmi_mask_q;
  assign int_defaults.irq_mask   = 1'b1;
  assign int_defaults.irq_enable = 1'b1;
  assign int_defaults.irq_level  = 1'b1;
  assign int_defaults.pullup_on  = 1'b1;

  // Events: external, watchdog, clock failure sample outcomes and sequence done.
  always_ff @(posedge aclk) begin
    if (!aresetn) pin_prev_q <= 1'b0;
    else pin_prev_q <= (state_q == ST_IDLE);
  end
  assign events[0] = sample_now & pin_low;
  assign events[1] = sample_now & ~pin_low & ~cf_latch_q & wd_latch_q;
  assign events[2] = sample_now & ~pin_low & cf_latch_q;
  assign events[3] = (state_q == ST_IDLE) & ~pin_prev_q;

  // AXI4-Lite write channel capture; address and data in either order.
  assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_q & ~s_axi_bvalid;
  assign do_write      = aw_q & w_q & ~s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
      end
      if (do_write) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= ({awaddr_q[11:2], 2'b00} == `REG_STATUS ||
                        {awaddr_q[11:2], 2'b00} == `REG_MASK ||
                        {awaddr_q[11:2], 2'b00} == `REG_CONTROL) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; a new event wins over a write-one clear in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q  <= 4'h0;
      mask_q    <= 4'h0;
      control_q <= `CONTROL_RESET;
    end else begin
      status_q <= (status_q & ~((do_write && {awaddr_q[11:2], 2'b00} == `REG_STATUS &&
                   s_axi_wstrb[0]) ? wdata_q[3:0] : 4'h0)) | events;
      if (do_write && {awaddr_q[11:2], 2'b00} == `REG_MASK && s_axi_wstrb[0])
        mask_q <= wdata_q[3:0];
      if (do_write && {awaddr_q[11:2], 2'b00} == `REG_CONTROL && s_axi_wstrb[0])
        control_q <= wdata_q[1:0];
    end
  end

  // Level interrupt: high while any sticky bit with its mask bit set stands.
  assign irq = |(status_q & mask_q);

  // Read channel: one cycle to answer, held until rready.
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case ({s_axi_araddr[11:2], 2'b00})
        `REG_STATUS:  s_axi_rdata <= {28'h0, status_q};
        `REG_MASK:    s_axi_rdata <= {28'h0, mask_q};
        `REG_CONTROL: s_axi_rdata <= {30'h0, control_q};
        `REG_VECTOR:  s_axi_rdata <= {10'h000, mode_latched, wd_latch_q, cf_latch_q,
                                      core_reset_n, reset_vector};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> reset_sequencer_properties.sv
// Concurrent checks on the reset sequencer ports, bound into the design.
`timescale 1ns/100ps
`include "reset_seq_defs.svh"
module reset_seq_checker
  import reset_seq_pkg::*;
#(
  parameter int STARTUP_CYCLES = `OSC_STARTUP_CYCLES
) (
  // Clock and reset.
  input wire logic          aclk,
  input wire logic          aresetn,
  // Reset pin and core side.
  input wire logic          reset_pin_i,
  input wire logic          reset_pin_oe_n,
  input wire logic          core_reset_n,
  input wire logic          mode_pulldown_en,
  input wire logic [2:0]    mode_latched,
  input wire logic [15:0]   reset_vector,
  input wire int_defaults_t int_defaults,
  // Read channel.
  input wire logic [1:0]    s_axi_rresp,
  input wire logic          s_axi_rvalid
);
  logic [13:0] low_q;
  logic [4:0]  high_q;
  logic        por_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Length of the present low drive, and time since the drive was released.
  always_ff @(posedge aclk) begin
    low_q <= (!aresetn || reset_pin_oe_n) ? 14'h0 : low_q + 14'h1;
  end
  always_ff @(posedge aclk) begin
    high_q <= (!aresetn || !reset_pin_oe_n) ? 5'h0 : high_q + {4'h0, high_q != 5'h1F};
  end
  // Power-on and clock-failure sequences carry the start-up stretch; only power-on is tracked here.
  always_ff @(posedge aclk) begin
    por_q <= !aresetn || (por_q && !reset_pin_oe_n);
  end
  pin_hold_core_a: assert property (!reset_pin_oe_n |-> !core_reset_n)
    else $error("Core released while pin driven low.");
  ext_cause_a: assert property ($fell(reset_pin_i) && core_reset_n |-> ##[1:5] !core_reset_n)
    else $error("External low did not start a reset.");
  drive_len_a: assert property ($rose(reset_pin_oe_n) |-> low_q >= 14'h10)
    else $error("Low drive too short.");
  startup_a: assert property ($rose(reset_pin_oe_n) && por_q |-> low_q >= STARTUP_CYCLES + 16)
    else $error("Start-up stretch too short.");
  settle_a: assert property ($rose(core_reset_n) |-> high_q >= 5'h9)
    else $error("Core released before the sample point.");
  vec_legal_a: assert property (core_reset_n |-> reset_vector inside
    {`VEC_NORMAL, `VEC_CLOCK_FAIL, `VEC_WATCHDOG}) else $error("Illegal vector.");
  pulldown_a: assert property (!core_reset_n |-> mode_pulldown_en)
    else $error("Mode pull-downs off in reset.");
  latch_hold_a: assert property (core_reset_n && $past(core_reset_n) |->
    $stable(mode_latched) && $stable(reset_vector)) else $error("Latched state moved.");
  nmi_set_a: assert property ($rose(core_reset_n) |-> int_defaults.nmi_mask)
    else $error("Nonmaskable mask clear after reset.");
  irq_dflt_a: assert property ($rose(core_reset_n) |-> int_defaults[3:0] == 4'hF)
    else $error("Maskable request defaults wrong.");
  cover property ($rose(core_reset_n) && reset_vector == `VEC_WATCHDOG);
  cover property ($rose(core_reset_n) && reset_vector == `VEC_CLOCK_FAIL);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind reset_sequencer reset_seq_checker #(.STARTUP_CYCLES(STARTUP_CYCLES)) chk_i (
  .aclk, .aresetn, .reset_pin_i, .reset_pin_oe_n, .core_reset_n, .mode_pulldown_en,
  .mode_latched, .reset_vector, .int_defaults, .s_axi_rresp, .s_axi_rvalid);

// >>> reset_board.sv
// Board model on the reset pin: pull-up, slow rise and an external low source.
`timescale 1ns/100ps
module reset_board (
  // Clock and device drive.
  input  wire logic       aclk,
  input  wire logic       reset_pin_o,
  input  wire logic       reset_pin_oe_n,
  // Board controls.
  input  wire logic       ext_low,
  input  wire logic [2:0] rise_dly,
  // Resolved pin level.
  output logic            reset_pin
);
  logic [2:0] rise_q = 3'h0;
  // The RC rise is kept below seven cycles, or the device would judge a false external reset.
  always_ff @(posedge aclk) begin
    rise_q <= (!reset_pin_oe_n || ext_low) ? rise_dly : rise_q - {2'h0, rise_q != 3'h0};
  end
  // Open drain: any low driver wins, otherwise the pull-up lifts the wire.
  assign reset_pin = !reset_pin_oe_n ? reset_pin_o : !(ext_low || rise_q != 3'h0);
endmodule

// >>> tb_top.sv
// Bench: board model on the reset pin, bus tasks and a result monitor.
`timescale 1ns/100ps
`include "reset_seq_defs.svh"
module tb_top
  import reset_seq_pkg::*;
;
  logic aclk, aresetn = 1'b0, watchdog_timeout = 1'b0, clock_fail = 1'b0, ext_low = 1'b0;
  logic mode_pin_a = 1'b0, mode_pin_b = 1'b0, special_mode_pin_n = 1'b0, nmi_mask_clear = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, reset_pin_i, reset_pin_o, reset_pin_oe_n, core_reset_n, irq, core_q;
  logic [11:0]   s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0]   s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  logic [2:0]    mode_latched, rise_dly = 3'h0;
  logic [15:0]   reset_vector;
  logic [15:0]   vecs[4] = '{`VEC_WATCHDOG, `VEC_CLOCK_FAIL, `VEC_NORMAL, `VEC_NORMAL};
  logic [3:0]    stat[4] = '{4'hA, 4'hC, 4'h9, 4'h9};
  int_defaults_t int_defaults;
  logic [33:0]   eq[$];
  logic [23:0]   vq[$];
  int            miscompares = 0;
  int            compares = 0;
  reset_sequencer #(.STARTUP_CYCLES(16)) uut (.aclk, .aresetn, .watchdog_timeout, .clock_fail,
    .reset_pin_i, .reset_pin_o, .reset_pin_oe_n, .mode_pin_a, .mode_pin_b, .special_mode_pin_n,
    .mode_pulldown_en(), .mode_latched, .core_reset_n, .reset_vector, .int_defaults,
    .nmi_mask_clear, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  reset_board brd (.aclk, .reset_pin_o, .reset_pin_oe_n, .ext_low, .rise_dly,
    .reset_pin(reset_pin_i));
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Write with both halves offered together; each is released once taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    eq.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    eq.push_back(e);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Raise one cause, or watchdog plus external low when k is 3; the external low is held past the sample point so it is seen.
  task automatic cause(input int k, input logic [31:0] m);
    wr(`REG_MASK, m, 2'h0);
    {special_mode_pin_n, mode_pin_b, mode_pin_a} <= 3'($urandom);
    rise_dly <= 3'($urandom_range(5));
    @(posedge aclk);
    vq.push_back({special_mode_pin_n, mode_pin_b, mode_pin_a, vecs[k], 5'h1F});
    watchdog_timeout <= (k == 0 || k == 3);
    clock_fail <= (k == 1);
    ext_low <= (k >= 2);
    repeat (4) @(posedge aclk);
    {watchdog_timeout, clock_fail} <= 2'h0;
    repeat (56) @(posedge aclk);
    ext_low <= 1'b0;
    while (!core_reset_n) @(posedge aclk);
    chk(irq, m != 0);
    rd(`REG_MASK, {2'h0, m});
  endtask
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Results are judged in arrival order against the notes left by the driver.
  always @(posedge aclk) begin
    if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
      chk(s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0}, eq.pop_front());
    end
    if (core_reset_n && !core_q) begin
      chk({mode_latched, reset_vector, int_defaults}, vq.pop_front());
    end
    core_q <= core_reset_n;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h529A04C4));
    vq.push_back({3'h0, `VEC_NORMAL, 5'h1F});
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    while (!core_reset_n) @(posedge aclk);
    rd(`REG_VECTOR, {15'h0, 3'h1, `VEC_NORMAL});
    rd(12'h100, {2'h2, 32'h0});
    wr(12'h104, 32'h1, 2'h2);
    nmi_mask_clear <= 1'b1;
    @(posedge aclk);
    nmi_mask_clear <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(int_defaults.nmi_mask, 1'b0);
    wr(`REG_CONTROL, 32'h0, 2'h0);
    rd(`REG_CONTROL, 34'h0);
    {watchdog_timeout, clock_fail} <= 2'h3;
    repeat (10) @(posedge aclk);
    {watchdog_timeout, clock_fail} <= 2'h0;
    chk(core_reset_n, 1'b1);
    repeat (3) @(posedge aclk);
    wr(`REG_CONTROL, 32'h3, 2'h0);
    for (int k = 0; k < 4; k++) begin
      cause(k, (k == 1) ? 32'h0 : 32'hF);
      rd(`REG_STATUS, {30'h0, stat[k]});
      wr(`REG_STATUS, 32'hF, 2'h0);
      rd(`REG_STATUS, 34'h0);
      chk(irq, 1'b0);
    end
    stop_test();
  end
endmodule
